/* dv/chg_partner.sv */
// Purpose: Behavioural charger analogue loops and pack thermistor
// Assumes: Cell level steps once a cycle while charge current flows, rise_en is high and it is below cap
// Notes: Knobs come from the bench; levels change just after an edge
`timescale 1ns/10ps
`default_nettype none
module chg_partner (
    input wire logic ref_clk, // Clock
    input wire logic reset, // Sync reset
    input wire logic charge_on, // Charge path on
    input wire logic cv_mode, // Voltage regulation
    input wire logic restart, // New cycle, empties cell
    input wire logic rise_en, // Cell accepts charge
    input wire logic hot, // Pack out of range
    input wire logic nopack, // No thermistor fitted
    input wire logic [1:0] reduce, // Reducing loop select
    input wire logic [4:0] cap, // Highest cell level
    output logic load_priority_loop, // Load loop active
    output logic low_vin_loop, // Input loop active
    output logic thermal_loop, // Thermal loop active
    output logic [8:0] current_ratio, // Current over set
    output logic bat_above_lowv, // Above low threshold
    output logic bat_at_reg, // At regulation
    output logic current_at_term, // Tapered to the end
    output logic temp_ok, // Pack in range
    output logic sense_above_dis // Sense pin high
);
    logic [4:0] vbat_q;
    logic [3:0] taper_q;

    // Cell level rises only while charge current flows
    always_ff @(posedge ref_clk) begin
        if (reset || restart) begin
            vbat_q <= 5'h00;
        end else if (charge_on && rise_en && vbat_q < cap) begin
            vbat_q <= vbat_q + 5'h01;
        end
    end

    // Current tapers off after a spell at regulation
    always_ff @(posedge ref_clk) begin
        if (reset || !cv_mode) begin
            taper_q <= 4'h0;
        end else if (taper_q != 4'hF) begin
            taper_q <= taper_q + 4'h1;
        end
    end

    // Comparator levels seen by the supervisor
    assign bat_above_lowv = vbat_q >= 5'h06;
    assign bat_at_reg = vbat_q >= 5'h0C;
    assign current_at_term = taper_q >= 4'h8;
    assign load_priority_loop = reduce == 2'h1;
    assign low_vin_loop = reduce == 2'h2;
    assign thermal_loop = reduce == 2'h3;
    // Half current while any loop holds it back
    assign current_ratio = (reduce != 2'h0) ? 9'h080 : 9'h100;
    assign temp_ok = !hot;
    assign sense_above_dis = nopack;
endmodule
`default_nettype wire

/* dv/chg_sup_tb_top.sv */
// Purpose: Self-checking bench for the charger supervisor
// Assumes: Short tick of 4 cycles, limits of 5 and 20 ticks
// Notes: Register cases in a table, phase cases by hand
`timescale 1ns/10ps
`default_nettype none
`include "chg_sup_cfg.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module chg_sup_tb_top;
    typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] r; logic e;} row_t;
    logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, new_cycle = 0;
    logic rise_en = 0, hot = 0, nopack = 0, saw_cv = 0, err_q, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic [1:0] reduce = 2'h0;
    logic [4:0] cap = 5'h1F;
    logic load_priority_loop, low_vin_loop, thermal_loop, bat_above_lowv, bat_at_reg;
    logic current_at_term, temp_ok, sense_above_dis, charge_on, cv_mode, precharge_mode;
    logic sensor_type, sense_enable, irq;
    logic [8:0] current_ratio;
    int errors = 0, n_compared = 0, cnt;
    row_t rows [7] = '{'{`CONFIG_OFS, 1'h0, 32'h0, 32'hD, 1'h0},
        '{`CONFIG_OFS, 1'h1, 32'h4, 32'h0, 1'h0}, '{`IRQ_STAT_OFS, 1'h0, 32'h0, 32'h0, 1'h0},
        '{`STATUS_OFS, 1'h0, 32'h0, 32'h0, 1'h0}, '{`IRQ_MASK_OFS, 1'h1, 32'h7, 32'h0, 1'h0},
        '{`IRQ_MASK_OFS, 1'h0, 32'h0, 32'h7, 1'h0}, '{12'h010, 1'h0, 32'h0, 32'h0, 1'h1}};

    always #4 ref_clk = ~ref_clk;
    // Note any visit to voltage regulation
    always @(posedge ref_clk) if (cv_mode === 1'b1) saw_cv <= 1'b1;

    chg_sup #(.TICK_CYC(4), .PRE_LIMIT(32'h5), .FAST_LIMIT(32'h14)) DUT (.ref_clk, .reset,
        .clk_en(1'b1), .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .load_priority_loop, .low_vin_loop, .thermal_loop, .current_ratio, .bat_above_lowv,
        .bat_at_reg, .current_at_term, .temp_ok, .sense_above_dis, .new_cycle, .charge_on,
        .cv_mode, .precharge_mode, .sensor_type, .sense_enable, .irq);
    chg_partner partner (.ref_clk, .reset, .charge_on, .cv_mode, .restart(new_cycle), .rise_en,
        .hot, .nopack, .reduce, .cap, .load_priority_loop, .low_vin_loop, .thermal_loop,
        .current_ratio, .bat_above_lowv, .bat_at_reg, .current_at_term, .temp_ok,
        .sense_above_dis);

    // ---------------------------------------------
    // Bus cycles and helpers
    // ---------------------------------------------
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (k >= 20) errors++;
    endtask
    task automatic wait_st(input int b);
        for (int i = 0; i < 100; i++) begin
            apb(`STATUS_OFS, 1'b0, 32'h0);
            if (rd_q[b] === 1'b1) break;
        end
    endtask
    task automatic restart(input logic [31:0] cfg);
        apb(`CONFIG_OFS, 1'b1, cfg & 32'hE);
        new_cycle <= 1'b1;
        repeat (4) @(posedge ref_clk);
        new_cycle <= 1'b0;
        repeat (4) @(posedge ref_clk);
        apb(`CONFIG_OFS, 1'b1, cfg);
    endtask
    task automatic wait_fast();
        for (int i = 0; i < 60 && precharge_mode !== 1'b1; i++) @(posedge ref_clk);
        `CHK(precharge_mode, 1'b1)
        for (int i = 0; i < 60 && precharge_mode !== 1'b0; i++) @(posedge ref_clk);
        `CHK(precharge_mode, 1'b0)
    endtask
    task automatic complete_run();
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        complete_run();
    end

    // ---------------------------------------------
    // Tests
    // ---------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        `CHK(sensor_type, 1'b1)
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            `CHK(err_q, rows[i].e)
            if (!rows[i].w) `CHK(rd_q, rows[i].r)
        end
        `CHK(sensor_type, 1'b0)
        // Sensing off only with termination off and no pack
        for (int k = 0; k < 4; k++) begin
            nopack <= k[0];
            apb(`CONFIG_OFS, 1'b1, {30'h0, k[1], 1'b0} | 32'h8);
            repeat (6) @(posedge ref_clk);
            `CHK(sense_enable, !(k[0] && k[1]))
        end
        nopack <= 1'b0;
        // Cell never rises: pre-charge limit runs out
        restart(32'hD);
        wait_st(`ST_PRE_TO);
        `CHK(rd_q[1:0], 2'h2)
        repeat (3) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        repeat (40) @(posedge ref_clk);
        apb(`STATUS_OFS, 1'b0, 32'h0);
        `CHK(rd_q[5:0], 6'h02)
        apb(`IRQ_STAT_OFS, 1'b1, 32'h2);
        apb(`IRQ_STAT_OFS, 1'b0, 32'h0);
        `CHK(rd_q[2:0], 3'h0)
        `CHK(irq, 1'b0)
        // Hot pack in fast charge, then resume to done
        rise_en <= 1'b1;
        apb(`IRQ_MASK_OFS, 1'b1, 32'h0);
        restart(32'hD);
        wait_fast();
        hot <= 1'b1;
        repeat (6) @(posedge ref_clk);
        `CHK(charge_on, 1'b0)
        repeat (200) @(posedge ref_clk);
        apb(`STATUS_OFS, 1'b0, 32'h0);
        `CHK(rd_q[5:0], 6'h10)
        hot <= 1'b0;
        wait_st(`ST_TERM);
        `CHK(rd_q[2:0], 3'h4)
        `CHK(saw_cv, 1'b1)
        apb(`IRQ_STAT_OFS, 1'b0, 32'h0);
        `CHK(rd_q[2:0], 3'h4)
        `CHK(irq, 1'b0)
        // Fast limit at full and at half current
        cap <= 5'h08;
        for (int j = 0; j < 2; j++) begin
            restart(32'hD);
            wait_fast();
            reduce <= 2'(j * 3);
            for (cnt = 0; cnt < 400 && charge_on !== 1'b0; cnt++) @(posedge ref_clk);
            `CHK(cnt > 64 * (j + 1) && cnt < 96 * (j + 1), 1'b1)
            apb(`STATUS_OFS, 1'b0, 32'h0);
            `CHK(rd_q[1:0], 2'h1)
            reduce <= 2'h0;
        end
        // Each reducing loop holds off termination
        cap <= 5'h1F;
        for (int j = 1; j < 4; j++) begin
            reduce <= 2'(j);
            restart(32'hD);
            for (cnt = 0; cnt < 100 && cv_mode !== 1'b1; cnt++) @(posedge ref_clk);
            repeat (40) @(posedge ref_clk);
            apb(`STATUS_OFS, 1'b0, 32'h0);
            `CHK(rd_q[5:0], 6'h28)
            reduce <= 2'h0;
            wait_st(`ST_TERM);
            `CHK(rd_q[`ST_TERM], 1'b1)
        end
        // Timers off by enable bit or by termination off
        cap <= 5'h08;
        for (int j = 0; j < 2; j++) begin
            restart(j ? 32'hF : 32'h9);
            repeat (250) @(posedge ref_clk);
            apb(`STATUS_OFS, 1'b0, 32'h0);
            `CHK(rd_q[3:0], 4'h8)
        end
        complete_run();
    end
endmodule
`default_nettype wire

/* verilog/chg_sup.sv */
// Purpose: Charger phase control, safety timers and fault reporting
// Assumes: Analogue comparator levels arrive asynchronously
// Notes: Timers count in millisecond ticks scaled by current ratio
//
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "chg_sup_cfg.svh"
module chg_sup
    import chg_sup_pkg::*;
#(
    parameter int unsigned TICK_CYC = `TICK_CYC,
    parameter logic [31:0] PRE_LIMIT = 32'(`PRE_LIMIT_MS),
    parameter logic [31:0] FAST_LIMIT = 32'(`FAST_LIMIT_MS)
) (
    input wire logic ref_clk, // Clock
    input wire logic reset, // Sync reset, active high
    input wire logic clk_en, // Clock enable
    input wire logic [11:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic load_priority_loop, // Load loop reducing current
    input wire logic low_vin_loop, // Low input voltage loop
    input wire logic thermal_loop, // Junction thermal regulation
    input wire logic [8:0] current_ratio, // Actual over set current, /256
    input wire logic bat_above_lowv, // Above low battery threshold
    input wire logic bat_at_reg, // At regulation voltage
    input wire logic current_at_term, // Current at termination level
    input wire logic temp_ok, // Thermistor within safe window
    input wire logic sense_above_dis, // Sense above disable threshold
    input wire logic new_cycle, // Restart charging request
    output logic charge_on, // Charge path enabled
    output logic cv_mode, // Constant-voltage regulation
    output logic precharge_mode, // Pre-charge current select
    output logic sensor_type, // Thermistor curve select
    output logic sense_enable, // Temperature sensing enabled
    output logic irq // Level interrupt
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NS = 8;
    logic [NS-1:0] async_in;
    logic [NS-1:0] sync1_q;
    logic [NS-1:0] sync2_q;
    logic [8:0] ratio_q;
    logic [8:0] ratio_s_q;

    assign async_in = {new_cycle, sense_above_dis, temp_ok, current_at_term,
                       bat_at_reg, bat_above_lowv, low_vin_loop,
                       load_priority_loop | thermal_loop};

    // Two-stage sync per input bit
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else if (clk_en) begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // Ratio sampled through two stages as well
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ratio_q <= 9'h100;
            ratio_s_q <= 9'h100;
        end else if (clk_en) begin
            ratio_q <= current_ratio;
            ratio_s_q <= ratio_q;
        end
    end

    logic reduced;
    logic above_lowv;
    logic at_reg;
    logic at_term;
    logic temp_good;
    logic sense_hi;
    logic restart;
    logic restart_q;
    assign reduced = sync2_q[0] | sync2_q[1];
    assign above_lowv = sync2_q[2];
    assign at_reg = sync2_q[3];
    assign at_term = sync2_q[4];
    assign temp_good = sync2_q[5];
    assign sense_hi = sync2_q[6];

    // Rising edge of restart request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            restart_q <= 1'b0;
        end else if (clk_en) begin
            restart_q <= sync2_q[7];
        end
    end
    assign restart = sync2_q[7] & ~restart_q;

    // ------------------------------------------------------------
    // Configuration and APB slave
    // ------------------------------------------------------------
    logic [3:0] config_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic fast_to_q;
    logic pre_to_q;
    logic term_q;
    logic temp_bad_q;
    phase_t phase_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rdata;

    assign addr_ok = (paddr == `STATUS_OFS) || (paddr == `CONFIG_OFS) ||
                     (paddr == `IRQ_STAT_OFS) || (paddr == `IRQ_MASK_OFS);
    assign wr_en = psel & penable & pwrite & clk_en;
    assign rd_en = psel & penable & ~pwrite & clk_en;

    // Read mux
    always_comb begin
        rdata = 32'h0;
        case (paddr)
            `STATUS_OFS: begin
                rdata[`ST_FAST_TO] = fast_to_q;
                rdata[`ST_PRE_TO] = pre_to_q;
                rdata[`ST_TERM] = term_q;
                rdata[`ST_ACTIVE] = charge_on;
                rdata[`ST_TEMP_BAD] = temp_bad_q;
                rdata[`ST_REDUCED] = reduced;
            end
            `CONFIG_OFS: rdata[3:0] = config_q;
            `IRQ_STAT_OFS: rdata[2:0] = irq_stat_q;
            `IRQ_MASK_OFS: rdata[2:0] = irq_mask_q;
            default: rdata = 32'h0;
        endcase
    end

    // Zero-wait answer, error on unmapped address
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (rd_en) begin
                prdata <= 32'h0;
            end
            if (psel & ~penable & ~pwrite) begin
                prdata <= rdata;
            end
        end
    end

    // Configuration register
    // sensor select default
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            config_q <= `CONFIG_RST;
            irq_mask_q <= 3'h0;
        end else if (wr_en & pready) begin
            if (paddr == `CONFIG_OFS) begin
                config_q <= pwdata[3:0];
            end
            if (paddr == `IRQ_MASK_OFS) begin
                irq_mask_q <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Safety timers
    // ------------------------------------------------------------
    logic tmr_on;
    logic tick;
    logic [31:0] pre_cnt_q;
    logic [31:0] fast_cnt_q;
    logic sense_on;

    assign sense_on = ~(config_q[`CF_TERM_OFF] & sense_hi);
    assign tmr_on = config_q[`CF_TMR_EN] & ~config_q[`CF_TERM_OFF];

    rate_tick #(
        .BASE_CYC(TICK_CYC)
    ) u_tick (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .run(tmr_on & ~temp_bad_q & ((phase_q == PH_PRE) | (phase_q == PH_FAST) |
             (phase_q == PH_CV))),
        .ratio(reduced ? ratio_s_q : 9'h100),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Charge phase machine
    // ------------------------------------------------------------
    logic pre_exp;
    logic fast_exp;
    assign pre_exp = tmr_on & (pre_cnt_q >= PRE_LIMIT);
    assign fast_exp = tmr_on & (fast_cnt_q >= FAST_LIMIT);

    // Temperature fault tracking
    // pause and resume
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            temp_bad_q <= 1'b0;
        end else if (clk_en) begin
            temp_bad_q <= sense_on & ~temp_good;
        end
    end

    // Phase transitions and timer counts
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_q <= PH_IDLE;
            pre_cnt_q <= 32'h0;
            fast_cnt_q <= 32'h0;
        end else if (clk_en) begin
            case (phase_q)
                PH_IDLE: begin
                    pre_cnt_q <= 32'h0;
                    fast_cnt_q <= 32'h0;
                    if (config_q[`CF_CHG_EN]) begin
                        phase_q <= PH_PRE;
                    end
                end
                PH_PRE: begin
                    if (pre_exp) begin
                        phase_q <= PH_FAULT;
                    end else if (above_lowv) begin
                        phase_q <= PH_FAST;
                        fast_cnt_q <= 32'h0;
                    end else if (tick) begin
                        pre_cnt_q <= pre_cnt_q + 32'h1;
                    end
                end
                PH_FAST, PH_CV: begin
                    if (fast_exp) begin
                        phase_q <= PH_FAULT;
                    end else if (phase_q == PH_CV && at_term && !reduced &&
                                 !config_q[`CF_TERM_OFF] && !temp_bad_q) begin
                        phase_q <= PH_DONE;
                    end else begin
                        if (at_reg) begin
                            phase_q <= PH_CV;
                        end
                        if (tick) begin
                            fast_cnt_q <= fast_cnt_q + 32'h1;
                        end
                    end
                end
                PH_DONE, PH_FAULT: begin
                    if (restart) begin
                        phase_q <= PH_IDLE;
                    end
                end
                default: phase_q <= PH_IDLE;
            endcase
            if (!config_q[`CF_CHG_EN] && phase_q != PH_FAULT) begin
                phase_q <= PH_IDLE;
            end
        end
    end

    // Status flags, cleared by new cycle
    // timeout status bits
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fast_to_q <= 1'b0;
            pre_to_q <= 1'b0;
            term_q <= 1'b0;
        end else if (clk_en) begin
            if (phase_q == PH_FAST || phase_q == PH_CV) begin
                fast_to_q <= fast_to_q | fast_exp;
            end else if (restart) begin
                fast_to_q <= 1'b0;
            end
            if (phase_q == PH_PRE) begin
                pre_to_q <= pre_to_q | pre_exp;
            end else if (restart) begin
                pre_to_q <= 1'b0;
            end
            if (phase_q == PH_DONE) begin
                term_q <= 1'b1;
            end else if (phase_q != PH_IDLE) begin
                term_q <= 1'b0;
            end
        end
    end

    // Sticky interrupt status, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_stat_q <= 3'h0;
        end else if (clk_en) begin
            irq_stat_q <= (irq_stat_q &
                ~((wr_en & pready & (paddr == `IRQ_STAT_OFS)) ? pwdata[2:0] : 3'h0)) |
                {term_q == 1'b0 && phase_q == PH_DONE,
                 phase_q == PH_PRE && pre_exp,
                 (phase_q == PH_FAST || phase_q == PH_CV) && fast_exp};
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            charge_on <= 1'b0;
            cv_mode <= 1'b0;
            precharge_mode <= 1'b0;
            sensor_type <= 1'b1;
            sense_enable <= 1'b1;
            irq <= 1'b0;
        end else if (clk_en) begin
            charge_on <= ((phase_q == PH_PRE) | (phase_q == PH_FAST) |
                          (phase_q == PH_CV)) & ~temp_bad_q;
            cv_mode <= phase_q == PH_CV;
            precharge_mode <= phase_q == PH_PRE;
            sensor_type <= config_q[`CF_SENSOR];
            sense_enable <= sense_on;
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    pause_stops_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && temp_bad_q |=> !charge_on)
        else $error("charging not stopped on bad temperature");
    hold_counts_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && temp_bad_q && $past(temp_bad_q) && phase_q != PH_IDLE |=> $stable(fast_cnt_q))
        else $error("timer moved while paused");
    timer_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && config_q[`CF_TERM_OFF] |-> (!pre_exp && !fast_exp) ##1 !tick)
        else $error("timer active with termination off");
    no_term_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && reduced && phase_q == PH_CV |=> phase_q != PH_DONE)
        else $error("termination while current reduced");
    pre_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && phase_q == PH_PRE && pre_exp |=> pre_to_q && phase_q == PH_FAULT)
        else $error("pre-charge timeout not flagged");
    fast_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && phase_q == PH_FAST && fast_exp |=> fast_to_q)
        else $error("fast-charge timeout not flagged");
    fault_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && phase_q == PH_FAULT && !restart |=> phase_q == PH_FAULT)
        else $error("fault left without restart");
    sense_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && config_q[`CF_TERM_OFF] && sense_hi |=> !sense_enable)
        else $error("sensing not disabled");
endmodule
`default_nettype wire

/* verilog/chg_sup_cfg.svh */
// Purpose: Constants for the charger timer and fault supervisor
// Assumes: ref_clk at 125 MHz; APB with 32-bit data
// Notes: Offsets are byte addresses of aligned words
//
// Summary of operation
// - Slow safety timers in proportion to charge-current reduction.
// - Suppress termination detection while any current-reducing loop is active.
// - Flag pre-charge timeout if battery stays below low threshold too long.
// - Flag fast-charge timeout if termination current not reached in time.
// - Report each timeout as a status bit set to one.
// - Out-of-range pack temperature stops charging and freezes timers.
// - Safe temperature resumes charging from held timer counts.
// - Disable temperature sensing only if termination off and sense high.
// - Thermistor-type bit selects curve; default 10k curve 2, zero 100k.
// - Safety timers off when timer enable clear or termination disabled.
// - Pre-charge to fast charge at threshold, then constant voltage.
// - Raise termination-current done flag when current falls to termination.
`ifndef CHG_SUP_CFG_SVH
`define CHG_SUP_CFG_SVH

// -------------------------------------------------------------
// Register offsets
// -------------------------------------------------------------
`define STATUS_OFS 12'h000
`define CONFIG_OFS 12'h004
`define IRQ_STAT_OFS 12'h008
`define IRQ_MASK_OFS 12'h00C

// -------------------------------------------------------------
// Field positions
// -------------------------------------------------------------
`define ST_FAST_TO 0
`define ST_PRE_TO 1
`define ST_TERM 2
`define ST_ACTIVE 3
`define ST_TEMP_BAD 4
`define ST_REDUCED 5
`define CF_CHG_EN 0
`define CF_TERM_OFF 1
`define CF_TMR_EN 2
`define CF_SENSOR 3
`define IRQ_FAST 0
`define IRQ_PRE 1
`define IRQ_DONE 2

// -------------------------------------------------------------
// Reset values and timing
// -------------------------------------------------------------
`define CONFIG_RST 4'hD
`define CLK_MHZ 125
`define TICK_US 1000
`define TICK_CYC (`TICK_US * `CLK_MHZ)
`define PRE_LIMIT_MS 1800000
`define FAST_LIMIT_MS 18000000

`endif

/* verilog/chg_sup_pkg.sv */
// Purpose: Types for the charger timer and fault supervisor
// Assumes: Nothing beyond the configuration header
// Notes: Phase codes are fixed binary values
`default_nettype none
package chg_sup_pkg;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_PRE = 3'b001,
        PH_FAST = 3'b010,
        PH_CV = 3'b011,
        PH_DONE = 3'b100,
        PH_FAULT = 3'b101
    } phase_t;
endpackage
`default_nettype wire

/* verilog/rate_tick.sv */
// Purpose: Timer tick generator slowed by current reduction
// Assumes: Current ratio given as a fraction of 256
// Notes: Accumulates ratio each cycle while run is high; tick per full base period
`timescale 1ns/10ps
`default_nettype none
`include "chg_sup_cfg.svh"
module rate_tick #(
    parameter int unsigned BASE_CYC = `TICK_CYC
) (
    input wire logic ref_clk, // Clock
    input wire logic reset, // Sync reset
    input wire logic clk_en, // Clock enable
    input wire logic run, // Count while high
    input wire logic [8:0] ratio, // Current ratio over 256
    output logic tick // One-cycle tick
);
    localparam logic [39:0] LIMIT = 40'(BASE_CYC) * 40'd256;
    logic [39:0] acc_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_q <= 40'h0;
            tick <= 1'b0;
        end else if (clk_en) begin
            tick <= 1'b0;
            if (run) begin
                if (acc_q + 40'(ratio) >= LIMIT) begin
                    acc_q <= acc_q + 40'(ratio) - LIMIT;
                    tick <= 1'b1;
                end else begin
                    acc_q <= acc_q + 40'(ratio);
                end
            end
        end
    end
endmodule
`default_nettype wire
